// ==== rtl/bts_slave.sv ====
// bts_slave: test slave state machine with functional, burst and tag array modes
// assumes the tester holds valid until done and the core logic shares CLK
// Contract
// - write at offset zero sets test mode
// - address bits 10..2 select functional locations
// - status two packs debug and tap fields
// - status one low bits carry core flags
// - core stepped once after each write sequence
// - locations served in fixed write-then-read order
// - tester enters functional test, addresses 7FC
// - tester exits by writing zero, releases lines
// - tester writes previous and current vector data
// - first iteration uses zero data and masks
// - repeated data out reads are masked
// - vector capture clocks sampled on fixed edges
// - added offset sets burst length outside functional
// - no burst decoding in functional test mode
// - tag array four segments, 64 lines, 26 bits
// - tester loads segment and index before access
// - index, segment, pattern locations take their bits
// - array writes step index, invert or increment pattern
// - array read returns entry high, steps index
// - every burst beat repeats the store step
// - pattern unpacked from four bus byte fields
`timescale 1ns/1ps
module bts_slave #(
    parameter int SEGMENTS = 4,
    parameter int LINES = 64
) (
    input wire logic CLK,
    input wire logic RST_B,
    bts_link_if.slave LINK,
    input wire logic [31:0] DATA_OUT,
    input wire logic [31:0] COPROC_INSTRUCTION_BUS,
    input wire logic [31:0] COPROC_DATA_FROM_CORE,
    input wire logic [31:0] CORE_ADDRESS_OUTPUT,
    input wire logic [21:3] CORE_STATUS_ONE_HIGH,
    input wire logic COPROC_TRANSFER_FLAG_B,
    input wire logic ENDIANNESS_OUTPUT,
    input wire logic INSTRUCTION_EXECUTED_FLAG,
    input wire logic SCAN_DRIVE_OUT_FLAG,
    input wire logic DEBUG_ACKNOWLEDGE,
    input wire logic EMBEDDED_CLOCK_OUT,
    input wire logic [3:0] TAP_INSTRUCTION_BITS,
    input wire logic WATCH_UNIT_ZERO_MATCH,
    input wire logic WATCH_UNIT_ONE_MATCH,
    input wire logic [4:0] SCAN_CHAIN_SELECT,
    input wire logic [3:0] TAP_STATE_BITS,
    input wire logic [13:0] CORE_STATUS_TWO_LOW,
    output logic [31:0] COPROC_DATA_TO_CORE,
    output logic [31:0] CORE_INPUT_WORD,
    output logic [31:0] DATA_IN,
    output logic CORE_STEP,
    output logic [2:0] TEST_MODE
);
    localparam int DEPTH = SEGMENTS * LINES;
    localparam int RAM_AW = $clog2(DEPTH);

    initial begin
        if (SEGMENTS != (1 << bts_pkg::SEG_POP_W) || LINES != (1 << bts_pkg::INDEX_W)) begin
            $error("bts_slave: array shape must be 4 segments of 64 lines");
        end
    end

    typedef struct packed {
        logic [2:0] mode;
        logic [11:0] addr;
        logic [3:0] pos;
        logic [7:0] beats;
        logic [bts_pkg::INDEX_W-1:0] index;
        logic [bts_pkg::SEG_W-1:0] segment;
        logic [bts_pkg::PAT_W-1:0] pattern;
        logic [31:0] cp_in;
        logic [31:0] core_in;
        logic [31:0] data_in;
        logic step;
        logic done;
        logic [31:0] rdata;
    } bts_slave_state_t;

    bts_slave_state_t state_reg, state_next;
    logic [bts_pkg::PAT_W-1:0] tag_ram [DEPTH];
    logic ram_we;
    logic [RAM_AW-1:0] ram_addr;
    logic seg_populated;
    logic [31:0] status_one, status_two;
    logic take;

    // position in the sequence to address bit
    function automatic int loc_bit(input logic [3:0] p);
        unique case (p)
            4'h0: return 10;
            4'h1: return 9;
            4'h2: return 8;
            4'h3: return 7;
            4'h4: return 5;
            4'h5: return 6;
            4'h6: return 4;
            4'h7: return 3;
            default: return 2;
        endcase
    endfunction

    // first selected position at or after from, wrapping round
    function automatic logic [3:0] next_sel(input logic [11:0] a, input logic [3:0] from);
        logic [3:0] r;
        logic hit;
        r = 4'h0;
        hit = 1'b0;
        for (int i = bts_pkg::LOC_NUM - 1; i >= 0; i--) begin
            if (a[loc_bit(4'(i))]) begin
                r = 4'(i);
                if (4'(i) >= from) begin
                    hit = 1'b1;
                end
            end
        end
        for (int i = bts_pkg::LOC_NUM - 1; i >= 0; i--) begin
            if (a[loc_bit(4'(i))] && 4'(i) >= from) begin
                r = 4'(i);
            end
        end
        if (!hit) begin
            r = next_sel_first(a);
        end
        return r;
    endfunction

    function automatic logic [3:0] next_sel_first(input logic [11:0] a);
        logic [3:0] r;
        r = 4'h0;
        for (int i = bts_pkg::LOC_NUM - 1; i >= 0; i--) begin
            if (a[loc_bit(4'(i))]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // true when a selected write position lies after p
    function automatic logic write_after(input logic [11:0] a, input logic [3:0] p);
        logic r;
        r = 1'b0;
        for (int i = 0; i < bts_pkg::LOC_WRITES; i++) begin
            if (a[loc_bit(4'(i))] && 4'(i) > p) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    assign status_one = {10'h000, CORE_STATUS_ONE_HIGH,
        COPROC_TRANSFER_FLAG_B, ENDIANNESS_OUTPUT, INSTRUCTION_EXECUTED_FLAG};
    assign status_two = {SCAN_DRIVE_OUT_FLAG, DEBUG_ACKNOWLEDGE, EMBEDDED_CLOCK_OUT,
        TAP_INSTRUCTION_BITS, WATCH_UNIT_ZERO_MATCH, WATCH_UNIT_ONE_MATCH,
        SCAN_CHAIN_SELECT, TAP_STATE_BITS, CORE_STATUS_TWO_LOW};
    assign seg_populated = state_reg.segment[bts_pkg::SEG_W-1:bts_pkg::SEG_POP_W] == '0;
    assign ram_addr = {state_reg.segment[bts_pkg::SEG_POP_W-1:0], state_reg.index};
    assign take = LINK.valid && !state_reg.done;

    always_comb begin
        logic [5:0] loc;
        logic [7:0] blen;
        logic [3:0] p;
        loc = state_reg.addr[5:0];
        blen = 8'(1) << state_reg.addr[8:bts_pkg::BURST_LSB];
        p = next_sel(state_reg.addr, state_reg.pos);
        state_next = state_reg;
        state_next.done = take;
        state_next.step = 1'b0;
        ram_we = 1'b0;
        if (take && LINK.is_addr) begin
            state_next.addr = LINK.wdata[11:0];
            state_next.pos = 4'h0;
            state_next.beats = '0;
        end else if (take) begin
            state_next.rdata = '0;
            if (state_reg.mode == bts_pkg::MODE_FUNC && state_reg.addr[10:2] != '0) begin
                unique case (loc_bit(p))
                    10: state_next.cp_in = LINK.wr ? LINK.wdata : state_reg.cp_in;
                    9: state_next.core_in = LINK.wr ? LINK.wdata : state_reg.core_in;
                    8: state_next.data_in = LINK.wr ? LINK.wdata : state_reg.data_in;
                    7: state_next.rdata = DATA_OUT;
                    5: state_next.rdata = COPROC_INSTRUCTION_BUS;
                    6: state_next.rdata = COPROC_DATA_FROM_CORE;
                    4: state_next.rdata = status_one;
                    3: state_next.rdata = status_two;
                    default: state_next.rdata = CORE_ADDRESS_OUTPUT;
                endcase
                if (p < 4'(bts_pkg::LOC_WRITES) && LINK.wr && !write_after(state_reg.addr, p)) begin
                    state_next.step = 1'b1;
                end
                state_next.pos = p + 4'h1;
            end else if (state_reg.mode != bts_pkg::MODE_FUNC && state_reg.beats < blen) begin
                state_next.beats = state_reg.beats + 8'h01;
                if (loc == bts_pkg::OFS_STATE && LINK.wr) begin
                    if (LINK.wdata[2:0] <= bts_pkg::MODE_LAST) begin
                        state_next.mode = LINK.wdata[2:0];
                    end
                end else if (state_reg.mode == bts_pkg::MODE_TAG) begin
                    if (loc == bts_pkg::OFS_INDEX && LINK.wr) begin
                        state_next.index = LINK.wdata[5:0];
                    end else if (loc == bts_pkg::OFS_SEGMENT && LINK.wr) begin
                        state_next.segment = LINK.wdata[6:0];
                    end else if (loc == bts_pkg::OFS_PATTERN && LINK.wr) begin
                        state_next.pattern = {LINK.wdata[28:24], LINK.wdata[22:16],
                            LINK.wdata[14:8], LINK.wdata[6:0]};
                    end else if ((loc == bts_pkg::OFS_WR_INVERT || loc == bts_pkg::OFS_WR_INCR)
                        && LINK.wr) begin
                        ram_we = seg_populated;
                        state_next.index = state_reg.index + 6'h01;
                        state_next.pattern = (loc == bts_pkg::OFS_WR_INVERT) ?
                            ~state_reg.pattern : state_reg.pattern + 26'h0000001;
                    end else if (loc == bts_pkg::OFS_READ && !LINK.wr) begin
                        if (seg_populated) begin
                            state_next.rdata = {tag_ram[ram_addr], 6'h00};
                        end
                        state_next.index = state_reg.index + 6'h01;
                    end
                end
            end else if (state_reg.addr == 12'h000 && LINK.wr) begin
                if (LINK.wdata[2:0] <= bts_pkg::MODE_LAST) begin
                    state_next.mode = LINK.wdata[2:0];
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (ram_we) begin
            tag_ram[ram_addr] <= state_reg.pattern;
        end
    end

    assign LINK.done = state_reg.done;
    assign LINK.rdata = state_reg.rdata;
    assign COPROC_DATA_TO_CORE = state_reg.cp_in;
    assign CORE_INPUT_WORD = state_reg.core_in;
    assign DATA_IN = state_reg.data_in;
    assign CORE_STEP = state_reg.step;
    assign TEST_MODE = state_reg.mode;
endmodule

// ==== rtl/bts_pkg.sv ====
// bts_pkg: constants shared by the test slave, its tester and their link
// assumes one 40 MHz clock for both ends
package bts_pkg;
    localparam int CLK_MHZ = 40;
    localparam logic [2:0] MODE_EXIT = 3'h0;
    localparam logic [2:0] MODE_FUNC = 3'h1;
    localparam logic [2:0] MODE_TAG = 3'h2;
    localparam logic [2:0] MODE_LAST = 3'h6;
    localparam int LOC_NUM = 9;
    localparam int LOC_WRITES = 3;
    localparam int LOC_LSB = 2;
    localparam logic [5:0] OFS_STATE = 6'h00;
    localparam logic [5:0] OFS_INDEX = 6'h04;
    localparam logic [5:0] OFS_SEGMENT = 6'h08;
    localparam logic [5:0] OFS_PATTERN = 6'h0C;
    localparam logic [5:0] OFS_WR_INVERT = 6'h10;
    localparam logic [5:0] OFS_WR_INCR = 6'h14;
    localparam logic [5:0] OFS_READ = 6'h18;
    localparam int BURST_LSB = 6;
    localparam int INDEX_W = 6;
    localparam int SEG_W = 7;
    localparam int SEG_POP_W = 2;
    localparam int PAT_W = 26;
    localparam int READ_LSB = 6;
    localparam logic [4:0] CTL_START = 5'h00;
    localparam logic [4:0] CTL_WDATA = 5'h04;
    localparam logic [4:0] CTL_STATUS = 5'h08;
    localparam logic [4:0] CTL_RDATA = 5'h0C;
    localparam int CMD_WRITE = 1;
    localparam int CMD_ADDR = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage

// ==== rtl/bts_link_if.sv ====
// bts_link_if: tester-to-slave transfer link
// assumes both ends on the same clock; oe low means lines released
`timescale 1ns/1ps
interface bts_link_if;
    logic valid;
    logic is_addr;
    logic wr;
    logic [31:0] wdata;
    logic oe;
    logic done;
    logic [31:0] rdata;
    modport tester (output valid, is_addr, wr, wdata, oe, input done, rdata);
    modport slave (input valid, is_addr, wr, wdata, oe, output done, rdata);
endinterface

// ==== rtl/bts_tester.sv ====
// bts_tester: AXI4-Lite controlled tester driving the test slave link
// assumes software follows the vector sequence; one transfer at a time
`timescale 1ns/1ps
module bts_tester (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [4:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [4:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    bts_link_if.tester LINK
);
    typedef struct packed {
        logic aw_have;
        logic [4:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
        logic [31:0] link_wdata;
        logic link_valid;
        logic link_wr;
        logic link_is_addr;
        logic link_oe;
        logic finished;
        logic [31:0] link_rdata;
    } bts_tester_state_t;

    bts_tester_state_t state_reg, state_next;

    always_comb begin
        state_next = state_reg;
        if (S_AXI_AWVALID && !state_reg.aw_have && !state_reg.bvalid) begin
            state_next.aw_have = 1'b1;
            state_next.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !state_reg.w_have && !state_reg.bvalid) begin
            state_next.w_have = 1'b1;
            state_next.w_data = S_AXI_WDATA;
            state_next.w_strb = S_AXI_WSTRB;
        end
        if (state_reg.bvalid && S_AXI_BREADY) begin
            state_next.bvalid = 1'b0;
        end
        if (state_reg.rvalid && S_AXI_RREADY) begin
            state_next.rvalid = 1'b0;
        end
        if (state_reg.link_valid && LINK.done) begin
            // answer sampled on the rising edge
            state_next.link_valid = 1'b0;
            state_next.finished = 1'b1;
            state_next.link_rdata = LINK.rdata;
        end
        if (state_reg.aw_have && state_reg.w_have) begin
            state_next.aw_have = 1'b0;
            state_next.w_have = 1'b0;
            state_next.bvalid = 1'b1;
            if (state_reg.aw_addr == bts_pkg::CTL_WDATA && state_reg.w_strb == 4'hF) begin
                state_next.link_wdata = state_reg.w_data;
            end else if (state_reg.aw_addr == bts_pkg::CTL_START && !state_reg.link_valid
                && state_reg.w_strb[0]) begin
                // address 7FC, previous-vector data and zero masks come from software
                state_next.link_valid = state_reg.w_data[0];
                state_next.link_wr = state_reg.w_data[bts_pkg::CMD_WRITE];
                state_next.link_is_addr = state_reg.w_data[bts_pkg::CMD_ADDR];
                state_next.link_oe = state_reg.w_data[0];
                state_next.finished = 1'b0;
            end
        end
        if (!state_next.link_valid && !state_reg.link_valid) begin
            state_next.link_oe = 1'b0;
        end
        if (S_AXI_ARVALID && !state_reg.rvalid) begin
            state_next.rvalid = 1'b1;
            unique case (S_AXI_ARADDR)
                bts_pkg::CTL_WDATA: state_next.rdata = state_reg.link_wdata;
                bts_pkg::CTL_STATUS: state_next.rdata = {30'h0, state_reg.finished,
                    state_reg.link_valid};
                bts_pkg::CTL_RDATA: state_next.rdata = state_reg.link_rdata;
                default: state_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign S_AXI_AWREADY = !state_reg.aw_have && !state_reg.bvalid;
    assign S_AXI_WREADY = !state_reg.w_have && !state_reg.bvalid;
    assign S_AXI_BVALID = state_reg.bvalid;
    assign S_AXI_BRESP = bts_pkg::RESP_OKAY;
    assign S_AXI_ARREADY = !state_reg.rvalid;
    assign S_AXI_RVALID = state_reg.rvalid;
    assign S_AXI_RDATA = state_reg.rdata;
    assign S_AXI_RRESP = bts_pkg::RESP_OKAY;
    assign LINK.valid = state_reg.link_valid;
    assign LINK.wr = state_reg.link_wr;
    assign LINK.is_addr = state_reg.link_is_addr;
    assign LINK.wdata = state_reg.link_oe ? state_reg.link_wdata : 32'h00000000;
    assign LINK.oe = state_reg.link_oe;
endmodule

// ==== tb/bts_link_monitor.sv ====
// bts_link_monitor: protocol checks on the tester-to-slave link
// assumes one clock; inputs are the link interface signals as they are
`timescale 1ns/1ps
module bts_link_monitor (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic valid,
    input wire logic is_addr,
    input wire logic wr,
    input wire logic [31:0] wdata,
    input wire logic oe,
    input wire logic done,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    sequence s_req;
        valid && !done;
    endsequence
    sequence s_beat;
        s_req ##1 done;
    endsequence
    beat_answer_a: assert property (s_req |=> done)
        else $error("link beat not answered one cycle later");
    done_pulse_a: assert property (done |=> !done)
        else $error("link done longer than one cycle");
    done_cause_a: assert property (done |-> $past(valid))
        else $error("link done without a request");
    valid_drop_a: assert property (s_beat |=> !valid)
        else $error("request kept after its answer");
    req_hold_a: assert property (s_req |=> valid && $stable({wdata, is_addr, wr}))
        else $error("request changed before its answer");
    release_zero_a: assert property (!oe |-> wdata == 32'h0)
        else $error("data lines not released");
    drive_with_req_a: assert property (valid |-> oe)
        else $error("request while lines released");
    rdata_hold_a: assert property (!done |-> $stable(rdata))
        else $error("read data changed between beats");
endmodule

// ==== tb/test_bus_test_slave_state_machine.sv ====
// test_bus_test_slave_state_machine: tester and test slave joined by the link
// assumes software drives the tester over axi4-lite; bench models the core outputs
`timescale 1ns/1ps
module test_bus_test_slave_state_machine;
    typedef struct packed {
        logic [1:0] op;
        logic [31:0] d;
    } bts_row_t;
    localparam logic [1:0] OA = 2'h0;
    localparam logic [1:0] OW = 2'h1;
    localparam logic [1:0] ORD = 2'h2;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] awaddr = 5'h0;
    logic [4:0] araddr = 5'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, core_step;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata_axi, cp_to_core, core_in, data_in, rd;
    logic [2:0] test_mode;
    logic [31:0] dout = 32'h13579BDF;
    logic [31:0] coproc_instruction_bus = 32'h2468ACE0;
    logic [31:0] cpdo = 32'h0F1E2D3C;
    logic [31:0] core_address_output = 32'h80001FFC;
    logic [18:0] st1h = 19'h5A5A5;
    logic [2:0] st1l = 3'h5;
    logic [2:0] st2h = 3'h5;
    logic [3:0] ir = 4'hA;
    logic [1:0] wm = 2'h2;
    logic [4:0] scs = 5'h15;
    logic [3:0] tps = 4'h6;
    logic [13:0] st2l = 14'h2345;
    logic [31:0] steps = 32'h0;
    bts_row_t rows [43];
    int errors = 0;
    int n_checks = 0;

    bts_link_if link ();
    bts_tester u_bts_tester (.CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata_axi), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .LINK(link));
    bts_slave u_bts_slave (.CLK(clk), .RST_B(rst_b), .LINK(link), .DATA_OUT(dout),
        .COPROC_INSTRUCTION_BUS(coproc_instruction_bus), .COPROC_DATA_FROM_CORE(cpdo),
        .CORE_ADDRESS_OUTPUT(core_address_output), .CORE_STATUS_ONE_HIGH(st1h),
        .COPROC_TRANSFER_FLAG_B(st1l[2]), .ENDIANNESS_OUTPUT(st1l[1]),
        .INSTRUCTION_EXECUTED_FLAG(st1l[0]), .SCAN_DRIVE_OUT_FLAG(st2h[2]),
        .DEBUG_ACKNOWLEDGE(st2h[1]), .EMBEDDED_CLOCK_OUT(st2h[0]),
        .TAP_INSTRUCTION_BITS(ir), .WATCH_UNIT_ZERO_MATCH(wm[1]),
        .WATCH_UNIT_ONE_MATCH(wm[0]), .SCAN_CHAIN_SELECT(scs), .TAP_STATE_BITS(tps),
        .CORE_STATUS_TWO_LOW(st2l), .COPROC_DATA_TO_CORE(cp_to_core),
        .CORE_INPUT_WORD(core_in), .DATA_IN(data_in), .CORE_STEP(core_step),
        .TEST_MODE(test_mode));
    bts_link_monitor u_bts_link_monitor (.CLK(clk), .RST_B(rst_b), .valid(link.valid),
        .is_addr(link.is_addr), .wr(link.wr), .wdata(link.wdata), .oe(link.oe),
        .done(link.done), .rdata(link.rdata));

    initial begin
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (core_step === 1'b1) steps <= steps + 32'h1;
    end

    task automatic finish_test();
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bready && bvalid));
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rready && rvalid));
        d = rdata_axi;
        rready <= 1'b0;
    endtask

    // one link transfer through the tester registers
    task automatic lk(input logic [1:0] op, input logic [31:0] d);
        logic [31:0] s;
        if (op != ORD) axw(bts_pkg::CTL_WDATA, d);
        axw(bts_pkg::CTL_START, {29'h0, op == OA, op == OW, 1'b1});
        s = 32'h0;
        while (s[1] !== 1'b1) axr(bts_pkg::CTL_STATUS, s);
        if (op == ORD) axr(bts_pkg::CTL_RDATA, rd);
    endtask

    task automatic run_rows(input int a, input int b);
        for (int i = a; i <= b; i++) begin
            lk(rows[i].op, rows[i].d);
            if (rows[i].op == ORD) chk(rd, rows[i].d);
        end
    endtask

    function automatic logic [31:0] pack(input logic [25:0] p);
        return {3'h0, p[25:21], 1'h0, p[20:14], 1'h0, p[13:7], 1'h0, p[6:0]};
    endfunction

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        finish_test();
    end

    initial begin
        int n;
        logic [25:0] e;
        rows = '{'{OA, 32'h0}, '{OW, 32'h1}, '{OA, 32'h7FC}, '{OW, 32'h0},
            '{OW, 32'hA5A50001}, '{OW, 32'h11110008}, '{ORD, dout}, '{ORD, coproc_instruction_bus},
            '{ORD, cpdo}, '{ORD, {10'h0, st1h, st1l}}, '{ORD, {st2h, ir, wm, scs, tps, st2l}},
            '{ORD, core_address_output}, '{OA, 32'h100}, '{OW, 32'hCAFE0100}, '{OA, 32'h400},
            '{OW, 32'hC0DE0400}, '{OA, 32'h0}, '{OW, 32'h0}, '{OA, 32'h0}, '{OW, 32'h2},
            '{OA, 32'h4}, '{OW, 32'hFFFFFFFE}, '{OA, 32'h8}, '{OW, 32'hFFFFFF81},
            '{OA, 32'hC}, '{OW, 32'hFFFFFFFF}, '{OA, 32'h50}, '{OW, 32'h0}, '{OW, 32'h0},
            '{OA, 32'h54}, '{OW, 32'h0}, '{OW, 32'h0}, '{OA, 32'h14}, '{OW, 32'h0},
            '{OA, 32'h4}, '{OW, 32'h3E}, '{OA, 32'h98}, '{ORD, 32'hFFFFFFC0}, '{ORD, 32'h0},
            '{ORD, 32'hFFFFFFC0}, '{ORD, 32'h0}, '{OA, 32'h18}, '{ORD, 32'h40}};
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk({29'h0, test_mode}, {29'h0, bts_pkg::MODE_EXIT});
        axr(bts_pkg::CTL_STATUS, rd);
        chk(rd, 32'h0);
        axr(5'h1C, rd);
        chk(rd, 32'h0);
        run_rows(0, 15);
        chk({29'h0, test_mode}, {29'h0, bts_pkg::MODE_FUNC});
        chk(steps, 32'h3);
        chk(core_in, 32'hA5A50001);
        chk(data_in, 32'hCAFE0100);
        chk(cp_to_core, 32'hC0DE0400);
        run_rows(16, 42);
        // every burst size, one extra beat beyond each length
        for (int k = 7; k >= 0; k--) begin
            n = 1 << k;
            lk(OA, {26'h0, bts_pkg::OFS_INDEX});
            lk(OW, 32'h0);
            lk(OA, {26'h0, bts_pkg::OFS_PATTERN});
            lk(OW, pack(26'(k << 20)));
            lk(OA, {26'h0, bts_pkg::OFS_WR_INCR} + 32'(k << 6));
            repeat (n + 1) lk(OW, 32'h0);
            lk(OA, {26'h0, bts_pkg::OFS_READ});
            lk(ORD, 32'h0);
            e = (k >= 6) ? 26'((k << 20) + (k == 7 ? 64 : 0)) : 26'(((k + 1) << 20) + n);
            chk(rd, {e, 6'h0});
        end
        // unpopulated segment: store dropped, read gives zero
        lk(OA, {26'h0, bts_pkg::OFS_SEGMENT});
        lk(OW, 32'h45);
        lk(OA, {26'h0, bts_pkg::OFS_INDEX});
        lk(OW, 32'h0);
        lk(OA, {26'h0, bts_pkg::OFS_WR_INVERT});
        lk(OW, 32'h0);
        lk(OA, {26'h0, bts_pkg::OFS_INDEX});
        lk(OW, 32'h0);
        lk(OA, {26'h0, bts_pkg::OFS_READ});
        lk(ORD, 32'h0);
        chk(rd, 32'h0);
        // mode code above the last one is ignored
        lk(OA, 32'h0);
        lk(OW, 32'h7);
        chk({29'h0, test_mode}, {29'h0, bts_pkg::MODE_TAG});
        lk(OA, 32'h0);
        lk(OW, 32'h0);
        chk({29'h0, test_mode}, {29'h0, bts_pkg::MODE_EXIT});
        lk(OA, 32'h0);
        lk(OW, 32'h1);
        chk({29'h0, test_mode}, {29'h0, bts_pkg::MODE_FUNC});
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk({29'h0, test_mode}, {29'h0, bts_pkg::MODE_EXIT});
        finish_test();
    end
endmodule
